// [include/dac_port_cfg.svh]
// constants for the host write port: address, pointer codes, fifo sizes
`ifndef DAC_PORT_CFG_SVH
`define DAC_PORT_CFG_SVH
`define ADDR_FIXED_BITS 5'h15
`define BURST_POINTER 8'hFF
`define LAST_CHANNEL 5'h1F
`define FIRST_CHANNEL 5'h00
`define BITS_PER_BYTE 4'h8
`define FIFO_DEPTH 128
`define FIFO_AW 7
`define SYNC_W 30
`endif

// [include/dac_port_pkg.sv]
// types shared by the host write port and its write queue
`default_nettype none
package dac_port_pkg;
	// one queued register write
	typedef struct packed {
		logic [4:0] chan;
		logic [1:0] reg_sel;
		logic ab_sel;
		logic [13:0] data;
	} wr_rec_t;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_PTR,
		ST_DHI,
		ST_DLO,
		ST_IGNORE
	} rx_state_t;
endpackage
`default_nettype wire

// [include/wr_fifo_if.sv]
// carrier between the port logic and its write queue
`default_nettype none
interface wr_fifo_if;
	import dac_port_pkg::*;
	logic push_valid;
	logic push_ready;
	wr_rec_t push_data;
	logic pop_valid;
	logic pop_ready;
	wr_rec_t pop_data;
	modport port (output push_valid, push_data, pop_ready,
		input push_ready, pop_valid, pop_data);
	modport queue (input push_valid, push_data, pop_ready,
		output push_ready, pop_valid, pop_data);
endinterface
`default_nettype wire

// [core/write_fifo.sv]
// write queue in flip-flops with honest full and empty
`default_nettype none
`include "dac_port_cfg.svh"
module write_fifo (
	input wire logic i_clk,
	input wire logic i_rst,
	wr_fifo_if.queue q
);
	import dac_port_pkg::*;
	wr_rec_t mem_r [`FIFO_DEPTH];
	logic [`FIFO_AW:0] wptr_r;
	logic [`FIFO_AW:0] rptr_r;
	logic full;
	logic empty;

	// extra pointer bit separates full from empty
	assign empty = (wptr_r == rptr_r);
	assign full = (wptr_r[`FIFO_AW] != rptr_r[`FIFO_AW]) &&
		(wptr_r[`FIFO_AW-1:0] == rptr_r[`FIFO_AW-1:0]);
	assign q.push_ready = !full;
	assign q.pop_valid = !empty;
	assign q.pop_data = mem_r[rptr_r[`FIFO_AW-1:0]];

	// storage write, no reset needed on data
	always_ff @(posedge i_clk) begin
		if (q.push_valid && !full) begin
			mem_r[wptr_r[`FIFO_AW-1:0]] <= q.push_data;
		end
	end

	// pointers
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			wptr_r <= '0;
			rptr_r <= '0;
		end else begin
			if (q.push_valid && !full) begin
				wptr_r <= wptr_r + 1'b1;
			end
			if (q.pop_ready && !empty) begin
				rptr_r <= rptr_r + 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// [core/dac_host_write_port.sv]
// host write port: two-wire receive-only slave plus strobed parallel port
// Function
// R1 - acknowledge each accepted address or data byte by holding data low in ninth clock
// R2 - idle until start plus address 10101 with the two strap bits
// R3 - master always sends direction bit zero; device only receives
// R4 - address, pointer, two data bytes, stop updates one channel, every byte acknowledged
// R5 - without stop, next byte is a new pointer; three bytes per further channel
// R6 - register select bits inside the data bytes choose the target register
// R7 - stop anywhere ends repeated or burst mode and returns to idle
// R8 - pointer 0xFF starts burst mode at channel zero
// R9 - burst advances channel per data pair to 31, then back to pointer mode
// R10 - master must not use toggle selection during burst mode
// R11 - repeated start is accepted in place of a stop
// R12 - master retries a transfer whose acknowledge is missing
// R13 - strap low enables parallel port and disables the serial port
// R14 - write strobe rising edge with select low captures channel and data
// R15 - parallel data is a straight 14-bit word, bit 13 most significant
// R16 - register select inputs sampled with each parallel write pick the register
// R17 - parallel writes queue in 128 deep fifo; busy low while pending; full drops
// R18 - toggle bit picks register A or B only when toggle is enabled
// R19 - wrong address or read direction: no acknowledge, ignore until next start
// R20 - a channel is written only after both data bytes are acknowledged; code queues the write at the clock fall after the low byte, as its ack starts
`default_nettype none
`include "dac_port_cfg.svh"
module dac_host_write_port (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_interface_select_strap,
	input wire logic i_slave_addr_strap_hi,
	input wire logic i_slave_addr_strap_lo,
	input wire logic i_toggle_en,
	input wire logic i_scl,
	input wire logic i_sda_in,
	output logic o_sda_out,
	output logic o_sda_oe,
	input wire logic i_cs_n,
	input wire logic i_wr_n,
	input wire logic [4:0] i_channel_address_bus,
	input wire logic [13:0] i_parallel_data_word,
	input wire logic i_register_select_hi,
	input wire logic i_register_select_lo,
	input wire logic i_ab_select,
	output logic o_busy_n,
	output logic o_wr_valid,
	input wire logic i_wr_ready,
	output dac_port_pkg::wr_rec_t o_wr_rec
);
	import dac_port_pkg::*;

	wr_fifo_if fq ();
	write_fifo u_queue (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.q(fq.queue)
	);

	// every pin gathered into pins passes two flops before any logic reads it; i_wr_ready is read directly
	logic [`SYNC_W-1:0] pins;
	logic [`SYNC_W-1:0] meta_r;
	logic [`SYNC_W-1:0] pin_r;
	assign pins = {i_interface_select_strap, i_slave_addr_strap_hi, i_slave_addr_strap_lo,
		i_toggle_en, i_scl, i_sda_in, i_cs_n, i_wr_n, i_channel_address_bus,
		i_parallel_data_word, i_register_select_hi, i_register_select_lo, i_ab_select};
	always_ff @(posedge i_clk) begin
		meta_r <= pins;
		pin_r <= meta_r;
	end

	logic ser_mode;
	logic [1:0] strap_addr;
	logic tog_en;
	logic scl_s;
	logic sda_s;
	logic cs_n_s;
	logic wr_n_s;
	wr_rec_t par_rec;
	assign ser_mode = pin_r[29];
	assign strap_addr = pin_r[28:27];
	assign tog_en = pin_r[26];
	assign scl_s = pin_r[25];
	assign sda_s = pin_r[24];
	assign cs_n_s = pin_r[23];
	assign wr_n_s = pin_r[22];
	// straight 14-bit word, msb first on the bus (see R15)
	assign par_rec = '{chan: pin_r[21:17], data: pin_r[16:3],
		reg_sel: {pin_r[2], pin_r[1]}, ab_sel: pin_r[0] & tog_en};

	// previous levels for edge finding, all from second stage
	logic scl_d_r;
	logic sda_d_r;
	logic wr_n_d_r;
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
			wr_n_d_r <= 1'b1;
		end else begin
			scl_d_r <= scl_s;
			sda_d_r <= sda_s;
			wr_n_d_r <= wr_n_s;
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic start_ev;
	logic stop_ev;
	logic par_strobe;
	assign scl_rise = scl_s && !scl_d_r;
	assign scl_fall = !scl_s && scl_d_r;
	// start and repeated start look alike, both restart address phase (see R11)
	assign start_ev = ser_mode && scl_s && scl_d_r && sda_d_r && !sda_s;
	assign stop_ev = ser_mode && scl_s && scl_d_r && !sda_d_r && sda_s;
	// capture on write strobe rising edge while selected (see R14) (see R13)
	assign par_strobe = !ser_mode && wr_n_s && !wr_n_d_r && !cs_n_s;

	// serial receive state
	rx_state_t state_r;
	logic [7:0] shift_r;
	logic [3:0] bitcnt_r;
	logic ack_r;
	logic burst_r;
	logic [4:0] chan_r;
	logic ab_r;
	logic [7:0] hi_r;
	logic ser_push;
	wr_rec_t ser_rec;
	logic addr_ok;

	// direction bit must be zero, device never transmits (see R3) (see R2)
	assign addr_ok = (shift_r == {`ADDR_FIXED_BITS, strap_addr, 1'b0});
	// data word only formed from the completed low byte (see R6) (see R20)
	assign ser_rec = '{chan: chan_r, reg_sel: hi_r[7:6], ab_sel: ab_r,
		data: {hi_r[5:0], shift_r}};

	// pointer steps only after the pushed pair has left with the old channel (see R9)
	logic burst_step;
	assign burst_step = ser_push && burst_r;

	// byte framing, acknowledge and mode tracking
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state_r <= ST_IDLE;
			shift_r <= 8'h00;
			bitcnt_r <= 4'h0;
			ack_r <= 1'b0;
			burst_r <= 1'b0;
			chan_r <= `FIRST_CHANNEL;
			ab_r <= 1'b0;
			hi_r <= 8'h00;
			ser_push <= 1'b0;
		end else begin
			ser_push <= 1'b0;
			if (burst_step) begin
				chan_r <= chan_r + 5'h1; // see R9
			end
			if (!ser_mode || stop_ev) begin
				// stop ends repeated and burst modes at any point (see R7)
				state_r <= ST_IDLE;
				ack_r <= 1'b0;
				burst_r <= 1'b0;
				bitcnt_r <= 4'h0;
			end else if (start_ev) begin
				state_r <= ST_ADDR; // see R2 see R11
				ack_r <= 1'b0;
				burst_r <= 1'b0;
				bitcnt_r <= 4'h0;
			end else if (state_r != ST_IDLE) begin
				if (scl_rise && !ack_r && bitcnt_r != `BITS_PER_BYTE) begin
					shift_r <= {shift_r[6:0], sda_s};
					bitcnt_r <= bitcnt_r + 4'h1;
				end else if (scl_fall && ack_r) begin
					// ninth clock over, let go of the data line (see R1)
					ack_r <= 1'b0;
					bitcnt_r <= 4'h0;
				end else if (scl_fall && bitcnt_r == `BITS_PER_BYTE) begin
					bitcnt_r <= 4'h0;
					// hold data low through the ninth clock (see R1)
					ack_r <= (state_r != ST_IGNORE) && (state_r != ST_ADDR || addr_ok);
					case (state_r)
						ST_ADDR: begin
							// mismatch or read: stay silent until next start (see R19)
							state_r <= addr_ok ? ST_PTR : ST_IGNORE;
						end
						ST_PTR: begin
							state_r <= ST_DHI;
							if (shift_r == `BURST_POINTER) begin
								burst_r <= 1'b1; // see R8
								chan_r <= `FIRST_CHANNEL;
								ab_r <= 1'b0; // toggle unavailable in burst (see R10)
							end else begin
								chan_r <= shift_r[4:0];
								ab_r <= shift_r[5] & tog_en; // see R18
							end
						end
						ST_DHI: begin
							hi_r <= shift_r;
							state_r <= ST_DLO;
						end
						ST_DLO: begin
							ser_push <= 1'b1; // see R4 see R20
							if (burst_r && chan_r != `LAST_CHANNEL) begin
								state_r <= ST_DHI; // see R9
							end else begin
								// next byte is a fresh pointer (see R5) (see R9)
								state_r <= ST_PTR;
								burst_r <= 1'b0;
							end
						end
						default: begin
							state_r <= ST_IGNORE;
						end
					endcase
				end
			end
		end
	end

	// queue fill: one source per mode; full queue drops the write (see R17)
	assign fq.push_valid = ser_mode ? ser_push : par_strobe; // see R16
	assign fq.push_data = ser_mode ? ser_rec : par_rec;

	// output stage, stalls when the consumer holds ready low
	logic out_valid_r;
	wr_rec_t out_rec_r;
	assign fq.pop_ready = !out_valid_r || i_wr_ready;
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			out_valid_r <= 1'b0;
			out_rec_r <= '0;
		end else if (fq.pop_ready) begin
			out_valid_r <= fq.pop_valid;
			out_rec_r <= fq.pop_data;
		end
	end

	// busy low while any queued write is pending (see R17)
	logic busy_n_r;
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			busy_n_r <= 1'b1;
		end else begin
			busy_n_r <= !(fq.pop_valid || out_valid_r || fq.push_valid);
		end
	end

	// open-drain data line: only ever pulled low
	logic sda_oe_r;
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			sda_oe_r <= 1'b0;
		end else begin
			sda_oe_r <= ack_r && ser_mode && !stop_ev && !start_ev;
		end
	end

	assign o_sda_out = 1'b0;
	assign o_sda_oe = sda_oe_r;
	assign o_busy_n = busy_n_r;
	assign o_wr_valid = out_valid_r;
	assign o_wr_rec = out_rec_r;
endmodule
`default_nettype wire

// [sim/dac_port_assertions.sv]
// pin-level property checks for the host write port
`default_nettype none
module dac_port_assertions (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_interface_select_strap,
	input wire logic i_scl,
	input wire logic o_sda_oe,
	input wire logic i_cs_n,
	input wire logic i_wr_n,
	input wire logic o_busy_n,
	input wire logic o_wr_valid,
	input wire logic i_wr_ready,
	input wire dac_port_pkg::wr_rec_t o_wr_rec
);
	timeunit 1ns;
	timeprecision 1ns;
	import dac_port_pkg::*;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// the data line may only change hands while the clock is low
	ack_rise_a: assert property ($rose(o_sda_oe) |-> !i_scl) else $error("ack rise");
	ack_fall_a: assert property ($fell(o_sda_oe) |-> !i_scl) else $error("ack fall");
	ack_span_a: assert property ($rose(i_scl) && o_sda_oe |-> o_sda_oe [*8])
		else $error("ack dropped early");
	// a long parallel strap keeps the two-wire side silent
	serial_mute_a: assert property ((!i_interface_select_strap) [*8] |-> !o_sda_oe)
		else $error("serial side answered");
	strobe_take_a: assert property ($rose(i_wr_n) && !i_cs_n && !i_interface_select_strap
		|-> ##[1:6] !o_busy_n) else $error("strobe lost");
	// a record offered must wait unchanged for its taker
	rec_hold_a: assert property (o_wr_valid && !i_wr_ready |=> o_wr_valid && $stable(o_wr_rec))
		else $error("record moved");
	busy_pend_a: assert property (o_wr_valid |-> !o_busy_n) else $error("busy high");
	busy_lead_a: assert property ($rose(o_wr_valid) |-> !$past(o_busy_n)) else $error("no busy");
	cover property ($rose(o_sda_oe));
	cover property (o_wr_valid && !i_wr_ready);
	cover property ($rose(i_wr_n) && !i_cs_n && !i_interface_select_strap);
endmodule
bind dac_host_write_port dac_port_assertions chk (.*);
`default_nettype wire

// [sim/tw_master.sv]
// two-wire bus master model with an open-drain data line
`default_nettype none
module tw_master (
	output var logic o_scl,
	output wire logic o_sda,
	input wire logic i_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	logic drv_r = 1'h1;
	initial o_scl = 1'h1;
	// pull-up wins unless a party pulls low, so a release never shows stale data
	assign o_sda = drv_r & ~i_oe;
	// data moves mid low phase; low lasts 8 cycles so the answer can settle
	task automatic clk_bit(input logic b, output logic s);
		#80 drv_r = b;
		#80 o_scl = 1'h1;
		s = o_sda;
		#160 o_scl = 1'h0;
	endtask
	// works from idle and as a repeated start
	task automatic start();
		#80 drv_r = 1'h1;
		#80 o_scl = 1'h1;
		#80 drv_r = 1'h0;
		#80 o_scl = 1'h0;
	endtask
	task automatic stop();
		#80 drv_r = 1'h0;
		#80 o_scl = 1'h1;
		#80 drv_r = 1'h1;
		#80;
	endtask
	// msb first, then release for the ninth bit and report the answer
	task automatic send(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
		clk_bit(1'h1, s);
		ack = ~s;
	endtask
endmodule
`default_nettype wire

// [sim/testbench.sv]
// self-checking bench: two-wire and parallel writes through the host port
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fail_count++; \
	$display("mismatch at %0t got %h exp %h", $time, a, e); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import dac_port_pkg::*;
	logic i_clk = 1'h0, i_rst = 1'h1, strap = 1'h1, ahi = 1'h1, alo = 1'h0, tog = 1'h1;
	logic cs_n = 1'h1, wr_n = 1'h1, rhi = 1'h0, rlo = 1'h0, ab = 1'h0, ready = 1'h1;
	logic scl, sda, oe, busy_n, valid, sda_out;
	logic [4:0] chan = 5'h00;
	logic [13:0] pdata = 14'h0000;
	logic [7:0] lf = 8'h63, rl = 8'h63;
	wr_rec_t rec;
	wr_rec_t exp_q[$];
	wr_rec_t exp_rec;
	int fail_count = 0, compares = 0, cyc = 0;
	initial forever #10 i_clk = ~i_clk;
	dac_host_write_port DUT (.i_clk(i_clk), .i_rst(i_rst), .i_interface_select_strap(strap),
		.i_slave_addr_strap_hi(ahi), .i_slave_addr_strap_lo(alo), .i_toggle_en(tog),
		.i_scl(scl), .i_sda_in(sda), .o_sda_out(sda_out), .o_sda_oe(oe), .i_cs_n(cs_n),
		.i_wr_n(wr_n), .i_channel_address_bus(chan), .i_parallel_data_word(pdata),
		.i_register_select_hi(rhi), .i_register_select_lo(rlo), .i_ab_select(ab),
		.o_busy_n(busy_n), .o_wr_valid(valid), .i_wr_ready(ready), .o_wr_rec(rec));
	tw_master m (.o_scl(scl), .o_sda(sda), .i_oe(oe));
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic results();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic tx(input logic [7:0] b, input logic a);
		logic k;
		m.send(b, k);
		`CHK(k, a)
	endtask
	task automatic open(input logic a);
		m.start();
		tx({5'h15, ahi, alo, 1'h0}, a);
	endtask
	// expectation is noted before the low byte, since the record may beat its ack
	task automatic pair(input logic [4:0] c, input logic s);
		logic [7:0] h;
		logic [7:0] l;
		h = lfsr(lf);
		l = lfsr(h);
		lf = l;
		tx(h, 1'h1);
		exp_q.push_back({c, h[7:6], s, h[5:0], l});
		tx(l, 1'h1);
	endtask
	task automatic chw(input logic [7:0] p);
		tx(p, 1'h1);
		pair(p[4:0], p[5] & tog);
	endtask
	task automatic pw(input logic [21:0] r);
		{chan, rhi, rlo, ab, pdata} = r;
		wr_n = 1'h0;
		repeat (3) @(posedge i_clk);
		#2 wr_n = 1'h1;
		if (!cs_n) exp_q.push_back({r[21:15], r[14] & tog, r[13:0]});
		repeat (3) @(posedge i_clk);
		#2;
	endtask
	// consumer stalls at random
	always @(posedge i_clk) begin
		rl <= lfsr(rl);
		ready <= rl[0] | rl[1];
	end
	always @(posedge i_clk) begin
		if (valid === 1'h1 && ready === 1'h1) begin
			// pop once, so a mismatch report cannot eat a second note
			if (exp_q.size() == 0) `CHK(1'h1, 1'h0)
			else begin
				exp_rec = exp_q.pop_front();
				`CHK(rec, exp_rec)
			end
		end
	end
	// hang guard, well above the expected run
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 40000) begin
			fail_count++;
			results();
		end
	end
	initial begin
		repeat (5) @(posedge i_clk);
		#2 i_rst = 1'h0;
		repeat (4) @(posedge i_clk);
		#2 open(1'h1);
		chw(8'h25);
		chw(8'h1F);
		m.stop();
		{ahi, alo} = 2'h1;
		m.start();
		tx(8'hAC, 1'h0);
		tx(8'h03, 1'h0);
		m.stop();
		m.start();
		tx(8'hAB, 1'h0);
		m.stop();
		open(1'h1);
		chw(8'h02);
		open(1'h1);
		tx(8'h07, 1'h1);
		tx(8'h41, 1'h1);
		m.stop();
		tog = 1'h0;
		open(1'h1);
		tx(8'hFF, 1'h1);
		for (int c = 0; c < 3; c++) pair(c[4:0], 1'h0);
		m.stop();
		open(1'h1);
		chw(8'h04);
		tx(8'hFF, 1'h1);
		for (int c = 0; c < 32; c++) pair(c[4:0], 1'h0);
		chw(8'h23);
		m.stop();
		strap = 1'h0;
		repeat (8) @(posedge i_clk);
		#2 open(1'h0);
		m.stop();
		cs_n = 1'h0;
		for (int i = 0; i < 12; i++) begin
			lf = lfsr(lf);
			tog = lf[0];
			pw({lf[4:0], lf[7:5], lf, i[5:0]});
		end
		cs_n = 1'h1;
		pw(22'h3FFFFF);
		for (int i = 0; i < 300 && exp_q.size() != 0; i++) @(posedge i_clk);
		repeat (4) @(posedge i_clk);
		#2;
		`CHK(exp_q.size(), 0)
		`CHK(busy_n, 1'h1)
		`CHK(sda_out, 1'h0)
		results();
	end
endmodule
`default_nettype wire
